// *** verilog/opa_cmp_pkg.sv ***
// Purpose: Shared constants, field layouts and helpers of the amplifier and comparator control.
// Assumes: One 8-bit register per word, byte addresses on a 4-bit register port.
// Notes:   Every offset, field position, reset value and filter length is named here once.
`default_nettype none
package opa_cmp_pkg;

    // Register addresses of the plain register port.
    localparam logic [3:0] ADDR_CMP_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_AMP0_CTRL  = 4'h1;
    localparam logic [3:0] ADDR_AMP1_CTRL  = 4'h2;
    localparam logic [3:0] ADDR_EDGE_SEL   = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK   = 4'h5;

    // Field positions of the comparator control register.
    localparam int CMP_UNUSED_BIT = 7;
    localparam int CMP_ON_BIT     = 6;
    localparam int CMP_INV_BIT    = 5;
    localparam int CMP_RES_BIT    = 4;
    localparam int CMP_DBC_LSB    = 2;
    localparam int CMP_BIAS_LSB   = 0;

    // Field positions of each amplifier offset control register.
    localparam int AMP_EN_BIT    = 7;
    localparam int AMP_OUT_BIT   = 6;
    localparam int AMP_MODE_BIT  = 5;
    localparam int AMP_REF_BIT   = 4;
    localparam int AMP_TRIM_LSB  = 0;

    // Event sources; the same index is used for synchronisers and interrupt bits.
    localparam int SRC_CMP  = 0;
    localparam int SRC_AMP0 = 1;
    localparam int SRC_AMP1 = 2;
    localparam int SRC_W    = 3;

    // Reset values.
    localparam logic [7:0]       CMP_CTRL_RESET = 8'h00;
    localparam logic [6:0]       AMP_CTRL_RESET = 7'h00;
    localparam logic [1:0]       EDGE_RESET     = 2'h0;
    localparam logic [SRC_W-1:0] IRQ_RESET      = 3'h0;

    // Debounce selections and their filter lengths in system clocks.
    localparam logic [1:0] DBC_NONE    = 2'h0;
    localparam logic [1:0] DBC_ONE     = 2'h1;
    localparam logic [1:0] DBC_FOUR    = 2'h2;
    localparam logic [1:0] DBC_SIXTEEN = 2'h3;
    localparam logic [4:0] DBC_LEN_ONE     = 5'h01;
    localparam logic [4:0] DBC_LEN_FOUR    = 5'h04;
    localparam logic [4:0] DBC_LEN_SIXTEEN = 5'h10;

    // Bias current codes, highest to lowest; the last code is not implemented.
    localparam logic [1:0] BIAS_HIGH   = 2'h0;
    localparam logic [1:0] BIAS_MID    = 2'h1;
    localparam logic [1:0] BIAS_LOW    = 2'h2;
    localparam logic [1:0] BIAS_UNIMPL = 2'h3;

    // Comparator interrupt edge selections.
    localparam logic [1:0] EDGE_FALL     = 2'h0;
    localparam logic [1:0] EDGE_RISE     = 2'h1;
    localparam logic [1:0] EDGE_BOTH     = 2'h2;
    localparam logic [1:0] EDGE_RESERVED = 2'h3;

    // Software-visible control of one amplifier.
    typedef struct packed {
        logic       enable;
        logic       mode;
        logic       ref_sel;
        logic [3:0] trim;
    } amp_ctrl_s;

    // Software-visible control of the comparator.
    typedef struct packed {
        logic       on;
        logic       invert;
        logic [1:0] debounce;
        logic [1:0] bias;
    } cmp_ctrl_s;

    // Switch controls {three, two, one} from offset mode and reference select.
    function automatic logic [2:0] switch_decode(input logic mode, input logic ref_sel);
        logic [2:0] sw;
        sw = 3'h3;
        if (mode && !ref_sel) begin
            sw = 3'h6;
        end else if (mode && ref_sel) begin
            sw = 3'h5;
        end
        return sw;
    endfunction

    // Filter length for a debounce selection; no filtering behaves as one clock of tracking.
    function automatic logic [4:0] debounce_len(input logic [1:0] sel);
        logic [4:0] len;
        len = DBC_LEN_ONE;
        if (sel == DBC_FOUR) begin
            len = DBC_LEN_FOUR;
        end else if (sel == DBC_SIXTEEN) begin
            len = DBC_LEN_SIXTEEN;
        end
        return len;
    endfunction

    // Read image of an amplifier register with its live output bit.
    function automatic logic [7:0] amp_read(input amp_ctrl_s a, input logic out);
        return {a.enable, out, a.mode, a.ref_sel, a.trim};
    endfunction

    // Amplifier control taken from a register write; the output bit is not writable.
    function automatic amp_ctrl_s amp_write(input logic [7:0] wdata);
        amp_ctrl_s a;
        a.enable  = wdata[AMP_EN_BIT];
        a.mode    = wdata[AMP_MODE_BIT];
        a.ref_sel = wdata[AMP_REF_BIT];
        a.trim    = wdata[AMP_TRIM_LSB +: 4];
        return a;
    endfunction

endpackage
`default_nettype wire

// *** verilog/cmp_debounce.sv ***
// Purpose: Debounce filter of the conditioned comparator result.
// Assumes: The input is already synchronised to the system clock.
// Notes:   The filter is held cleared while the comparator is off.
`timescale 1ns/1ps
`default_nettype none
module cmp_debounce (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       enable,
    input  wire logic [1:0] sel,
    input  wire logic       raw,
    output logic            filtered
);

    typedef struct packed {
        logic       level;
        logic [4:0] count;
    } dbc_state_s;

    dbc_state_s st_reg;
    dbc_state_s st_next;
    logic [4:0] len;

    // Next state: count clocks at a new level and take it once the count is met.
    always_comb begin
        st_next = st_reg;
        len     = opa_cmp_pkg::debounce_len(sel);
        if (!enable) begin
            st_next = '0;
        end else if (raw == st_reg.level) begin
            st_next.count = 5'h00;
        end else if ((st_reg.count + 5'h01) >= len) begin
            st_next.level = raw;
            st_next.count = 5'h00;
        end else begin
            st_next.count = st_reg.count + 5'h01;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Without filtering the synchronised level passes straight through.
    assign filtered = enable & ((sel == opa_cmp_pkg::DBC_NONE) ? raw : st_reg.level);

    // A change under four-clock filtering follows four clocks at the new level.
    property p_debounce_four;
        @(posedge clk) disable iff (!arst_n)
        ($changed(st_reg.level) && enable && $past(enable, 4)
         && $past(sel, 4) == opa_cmp_pkg::DBC_FOUR && sel == opa_cmp_pkg::DBC_FOUR)
        |-> ($past(raw, 1) == st_reg.level) && ($past(raw, 2) == st_reg.level)
            && ($past(raw, 3) == st_reg.level) && ($past(raw, 4) == st_reg.level);
    endproperty
    a_debounce_four: assert property (p_debounce_four) else $error("four clock debounce broken");

    // Under sixteen-clock filtering no filtered level is taken before the count reaches the selected length.
    property p_no_early_change;
        @(posedge clk) disable iff (!arst_n)
        (enable && sel == opa_cmp_pkg::DBC_SIXTEEN && raw != st_reg.level
         && st_reg.count < 5'h0F) |=> !$changed(st_reg.level) || !$past(enable);
    endproperty
    a_no_early_change: assert property (p_no_early_change) else $error("filter changed early");

    // While off the filter sits cleared.
    property p_off_cleared;
        @(posedge clk) disable iff (!arst_n)
        !enable |=> (st_reg.count == 5'h00) && !st_reg.level;
    endproperty
    a_off_cleared: assert property (p_off_cleared) else $error("filter not cleared when off");

endmodule
`default_nettype wire

// *** verilog/opa_comparator_control.sv ***
// Purpose: Register file and digital control of two amplifiers and one comparator.
// Assumes: CMP_RAW and AMP*_OUT are asynchronous analog outputs; the register port is
//          on CLK_SYS and never waits.
// Notes:   Interrupt status bits are sticky, cleared by writing a one.
//
// Overview of operation
// - Each amplifier's offset mode and reference select decode into its three switches.
// - Comparator control bit 6 switches the comparator on and resets to zero.
// - Comparator control bit 5 inverts the comparison result before the output bit.
// - Comparator control bit 4 is a read-only image of the conditioned result.
// - Bits 3 to 2 select no filtering or one, four or sixteen clocks of debounce.
// - Bits 1 to 0 drive the comparator bias current, with code 11 unimplemented.
// - Comparator control bit 7 always reads zero.
// - The comparator interrupt fires on falling, rising or both edges, with code 11 reserved.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module opa_comparator_control (
    input  wire logic       CLK_SYS,
    input  wire logic       ARST_N,
    input  wire logic [3:0] BUS_ADDR,
    input  wire logic [7:0] BUS_WDATA,
    input  wire logic       BUS_WRITE,
    input  wire logic       BUS_READ,
    output logic      [7:0] BUS_RDATA,
    input  wire logic       CMP_RAW,
    input  wire logic       AMP0_OUT,
    input  wire logic       AMP1_OUT,
    output logic            CMP_ON,
    output logic      [1:0] CMP_BIAS,
    output logic            CMP_RESULT,
    output logic            AMP0_ENABLE,
    output logic      [2:0] AMP0_SWITCH,
    output logic      [3:0] AMP0_TRIM,
    output logic            AMP1_ENABLE,
    output logic      [2:0] AMP1_SWITCH,
    output logic      [3:0] AMP1_TRIM,
    output logic            IRQ
);

    // Whole state of the block apart from the debounce filter, which u_debounce holds.
    typedef struct packed {
        opa_cmp_pkg::cmp_ctrl_s cmp;
        opa_cmp_pkg::amp_ctrl_s amp0;
        opa_cmp_pkg::amp_ctrl_s amp1;
        logic [1:0]             edge_sel;
        logic [2:0]             irq_status;
        logic [2:0]             irq_mask;
        logic [7:0]             rdata;
        logic [2:0]             sync1;
        logic [2:0]             sync2;
        logic [1:0]             amp_prev;
        logic                   cmp_prev;
    } ctl_state_s;

    ctl_state_s st_reg;
    ctl_state_s st_next;
    logic [2:0] event_hit;
    logic [2:0] clear_mask;
    logic       cond_raw;
    logic       cmp_filtered;
    logic       cmp_rise;
    logic       cmp_fall;

    assign cond_raw = st_reg.sync2[opa_cmp_pkg::SRC_CMP] ^ st_reg.cmp.invert;

    // Debounce of the conditioned comparator result.
    cmp_debounce u_debounce (
        .clk      (CLK_SYS),
        .arst_n   (ARST_N),
        .enable   (st_reg.cmp.on),
        .sel      (st_reg.cmp.debounce),
        .raw      (cond_raw),
        .filtered (cmp_filtered)
    );

    // Edges of the conditioned output against its value one clock earlier.
    assign cmp_rise = cmp_filtered & ~st_reg.cmp_prev;
    assign cmp_fall = ~cmp_filtered & st_reg.cmp_prev;

    // Next state: synchronisers, events, register writes and the registered read data.
    always_comb begin
        st_next    = st_reg;
        event_hit  = 3'h0;
        clear_mask = 3'h0;

        // Asynchronous analog outputs pass two flip-flops before use.
        st_next.sync1    = {AMP1_OUT, AMP0_OUT, CMP_RAW};
        st_next.sync2    = st_reg.sync1;
        st_next.amp_prev = st_reg.sync2[opa_cmp_pkg::SRC_AMP1:opa_cmp_pkg::SRC_AMP0];
        st_next.cmp_prev = cmp_filtered;

        unique case (st_reg.edge_sel)
            opa_cmp_pkg::EDGE_FALL: begin
                event_hit[opa_cmp_pkg::SRC_CMP] = cmp_fall;
            end
            opa_cmp_pkg::EDGE_RISE: begin
                event_hit[opa_cmp_pkg::SRC_CMP] = cmp_rise;
            end
            opa_cmp_pkg::EDGE_BOTH: begin
                event_hit[opa_cmp_pkg::SRC_CMP] = cmp_rise | cmp_fall;
            end
            opa_cmp_pkg::EDGE_RESERVED: begin
                event_hit[opa_cmp_pkg::SRC_CMP] = 1'b0;
            end
        endcase

        // Amplifier outputs raise an event on their falling edge.
        event_hit[opa_cmp_pkg::SRC_AMP0] = st_reg.amp_prev[0]
                                           & ~st_reg.sync2[opa_cmp_pkg::SRC_AMP0];
        event_hit[opa_cmp_pkg::SRC_AMP1] = st_reg.amp_prev[1]
                                           & ~st_reg.sync2[opa_cmp_pkg::SRC_AMP1];

        // Register writes.
        if (BUS_WRITE) begin
            unique case (BUS_ADDR)
                opa_cmp_pkg::ADDR_CMP_CTRL: begin
                    st_next.cmp.on       = BUS_WDATA[opa_cmp_pkg::CMP_ON_BIT];
                    st_next.cmp.invert   = BUS_WDATA[opa_cmp_pkg::CMP_INV_BIT];
                    st_next.cmp.debounce = BUS_WDATA[opa_cmp_pkg::CMP_DBC_LSB +: 2];
                    if (BUS_WDATA[opa_cmp_pkg::CMP_BIAS_LSB +: 2] != opa_cmp_pkg::BIAS_UNIMPL) begin
                        st_next.cmp.bias = BUS_WDATA[opa_cmp_pkg::CMP_BIAS_LSB +: 2];
                    end
                end
                opa_cmp_pkg::ADDR_AMP0_CTRL: begin
                    st_next.amp0 = opa_cmp_pkg::amp_write(BUS_WDATA);
                end
                opa_cmp_pkg::ADDR_AMP1_CTRL: begin
                    st_next.amp1 = opa_cmp_pkg::amp_write(BUS_WDATA);
                end
                opa_cmp_pkg::ADDR_EDGE_SEL: begin
                    st_next.edge_sel = BUS_WDATA[1:0];
                end
                opa_cmp_pkg::ADDR_IRQ_STATUS: begin
                    clear_mask = BUS_WDATA[2:0];
                end
                opa_cmp_pkg::ADDR_IRQ_MASK: begin
                    st_next.irq_mask = BUS_WDATA[2:0];
                end
                default: begin
                end
            endcase
        end

        // Sticky status: an event in the clearing cycle wins.
        st_next.irq_status = (st_reg.irq_status & ~clear_mask) | event_hit;

        // Read data stand only in the cycle after the read strobe.
        st_next.rdata = 8'h00;
        if (BUS_READ) begin
            unique case (BUS_ADDR)
                opa_cmp_pkg::ADDR_CMP_CTRL: begin
                    st_next.rdata = {1'b0, st_reg.cmp.on, st_reg.cmp.invert, cmp_filtered,
                                     st_reg.cmp.debounce, st_reg.cmp.bias};
                end
                opa_cmp_pkg::ADDR_AMP0_CTRL: begin
                    st_next.rdata = opa_cmp_pkg::amp_read(st_reg.amp0,
                                        st_reg.sync2[opa_cmp_pkg::SRC_AMP0]);
                end
                opa_cmp_pkg::ADDR_AMP1_CTRL: begin
                    st_next.rdata = opa_cmp_pkg::amp_read(st_reg.amp1,
                                        st_reg.sync2[opa_cmp_pkg::SRC_AMP1]);
                end
                opa_cmp_pkg::ADDR_EDGE_SEL: begin
                    st_next.rdata = {6'h00, st_reg.edge_sel};
                end
                opa_cmp_pkg::ADDR_IRQ_STATUS: begin
                    st_next.rdata = {5'h00, st_reg.irq_status};
                end
                opa_cmp_pkg::ADDR_IRQ_MASK: begin
                    st_next.rdata = {5'h00, st_reg.irq_mask};
                end
                default: begin
                    st_next.rdata = 8'h00;
                end
            endcase
        end
    end

    // State register with reset values.
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            st_reg            <= '0;
            st_reg.cmp        <= {opa_cmp_pkg::CMP_CTRL_RESET[opa_cmp_pkg::CMP_ON_BIT],
                                  opa_cmp_pkg::CMP_CTRL_RESET[opa_cmp_pkg::CMP_INV_BIT],
                                  opa_cmp_pkg::CMP_CTRL_RESET[3:0]};
            st_reg.amp0       <= opa_cmp_pkg::AMP_CTRL_RESET;
            st_reg.amp1       <= opa_cmp_pkg::AMP_CTRL_RESET;
            st_reg.edge_sel   <= opa_cmp_pkg::EDGE_RESET;
            st_reg.irq_status <= opa_cmp_pkg::IRQ_RESET;
            st_reg.irq_mask   <= opa_cmp_pkg::IRQ_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign AMP0_SWITCH = opa_cmp_pkg::switch_decode(st_reg.amp0.mode, st_reg.amp0.ref_sel);
    assign AMP1_SWITCH = opa_cmp_pkg::switch_decode(st_reg.amp1.mode, st_reg.amp1.ref_sel);

    // Amplifier enables and trim fields come straight from their registers.
    assign AMP0_ENABLE = st_reg.amp0.enable;
    assign AMP0_TRIM   = st_reg.amp0.trim;
    assign AMP1_ENABLE = st_reg.amp1.enable;
    assign AMP1_TRIM   = st_reg.amp1.trim;

    assign CMP_BIAS = st_reg.cmp.bias;

    assign CMP_ON     = st_reg.cmp.on;
    assign CMP_RESULT = cmp_filtered;

    // Register read data and the masked level interrupt.
    assign BUS_RDATA = st_reg.rdata;
    assign IRQ       = |(st_reg.irq_status & st_reg.irq_mask);

    // Offset mode with reference zero opens switch one and closes two and three.
    property p_switch_ref0;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (BUS_WRITE && BUS_ADDR == opa_cmp_pkg::ADDR_AMP0_CTRL
         && BUS_WDATA[opa_cmp_pkg::AMP_MODE_BIT] && !BUS_WDATA[opa_cmp_pkg::AMP_REF_BIT])
        |=> AMP0_SWITCH == 3'h6;
    endproperty
    a_switch_ref0: assert property (p_switch_ref0) else $error("offset mode ref0 switches wrong");

    // Amplifier mode closes switches one and two whatever the reference.
    property p_switch_normal;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        !st_reg.amp1.mode |-> AMP1_SWITCH == 3'h3 && !AMP1_SWITCH[2];
    endproperty
    a_switch_normal: assert property (p_switch_normal) else $error("normal mode switches wrong");

    // A write of the on bit shows on the comparator enable one clock later.
    property p_on_write;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (BUS_WRITE && BUS_ADDR == opa_cmp_pkg::ADDR_CMP_CTRL)
        |=> CMP_ON == $past(BUS_WDATA[opa_cmp_pkg::CMP_ON_BIT]);
    endproperty
    a_on_write: assert property (p_on_write) else $error("comparator on bit not applied");

    // Without filtering the output is the synchronised result with polarity applied.
    property p_polarity;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (CMP_ON && st_reg.cmp.debounce == opa_cmp_pkg::DBC_NONE)
        |-> CMP_RESULT == (st_reg.sync2[opa_cmp_pkg::SRC_CMP] ^ st_reg.cmp.invert);
    endproperty
    a_polarity: assert property (p_polarity) else $error("output polarity wrong");

    // The result bit read back equals the output in the cycle of the read strobe.
    property p_result_read;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (BUS_READ && BUS_ADDR == opa_cmp_pkg::ADDR_CMP_CTRL)
        |=> BUS_RDATA[opa_cmp_pkg::CMP_RES_BIT] == $past(CMP_RESULT)
            && BUS_RDATA[opa_cmp_pkg::CMP_ON_BIT] == CMP_ON;
    endproperty
    a_result_read: assert property (p_result_read) else $error("result bit read wrong");

    // The unused top bit of the comparator register never reads one.
    property p_top_bit_zero;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        $past(BUS_READ) && $past(BUS_ADDR) == opa_cmp_pkg::ADDR_CMP_CTRL
        |-> !BUS_RDATA[opa_cmp_pkg::CMP_UNUSED_BIT];
    endproperty
    a_top_bit_zero: assert property (p_top_bit_zero) else $error("unused bit read as one");

    // Writing the unimplemented bias code leaves the bias untouched.
    property p_bias_hold;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (BUS_WRITE && BUS_ADDR == opa_cmp_pkg::ADDR_CMP_CTRL
         && BUS_WDATA[opa_cmp_pkg::CMP_BIAS_LSB +: 2] == opa_cmp_pkg::BIAS_UNIMPL)
        |=> $stable(CMP_BIAS);
    endproperty
    a_bias_hold: assert property (p_bias_hold) else $error("unimplemented bias code taken");

    // While off the output stays low for as long as it is off.
    property p_off_low;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (!CMP_ON)[*2] |-> !CMP_RESULT && !$past(CMP_RESULT);
    endproperty
    a_off_low: assert property (p_off_low) else $error("output high while off");

    // A rising output under rising-edge select sets the comparator status bit.
    sequence s_rise_seen;
        st_reg.edge_sel == opa_cmp_pkg::EDGE_RISE && cmp_rise;
    endsequence
    property p_edge_rise;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        s_rise_seen |=> st_reg.irq_status[opa_cmp_pkg::SRC_CMP];
    endproperty
    a_edge_rise: assert property (p_edge_rise) else $error("rising edge not flagged");

    // Under falling-edge select a rising output raises nothing by itself.
    sequence s_fall_only;
        st_reg.edge_sel == opa_cmp_pkg::EDGE_FALL && !cmp_fall
        && !st_reg.irq_status[opa_cmp_pkg::SRC_CMP];
    endsequence
    property p_edge_fall_only;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        s_fall_only |=> !st_reg.irq_status[opa_cmp_pkg::SRC_CMP];
    endproperty
    a_edge_fall_only: assert property (p_edge_fall_only) else $error("flag set without fall");

endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Purpose: Self-checking bench of the amplifier and comparator control.
// Assumes: The bench drives the analog outputs and the register port itself.
// Notes:   Waits allow for the two-flop synchronisers ahead of the filter.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module tb;
    logic       CLK_SYS = 1'b0, ARST_N = 1'b0, BUS_WRITE = 1'b0, BUS_READ = 1'b0;
    logic [3:0] BUS_ADDR = 4'h0;
    logic [7:0] BUS_WDATA = 8'h00;
    logic       CMP_RAW = 1'b0, AMP0_OUT = 1'b0, AMP1_OUT = 1'b0;
    logic [7:0] BUS_RDATA;
    logic       CMP_ON, CMP_RESULT, AMP0_ENABLE, AMP1_ENABLE, IRQ;
    logic [1:0] CMP_BIAS;
    logic [2:0] AMP0_SWITCH, AMP1_SWITCH;
    logic [3:0] AMP0_TRIM, AMP1_TRIM;
    int         n_errors = 0, n_compared = 0;
    int         len;
    logic [2:0] e;

    opa_comparator_control dut (.CLK_SYS, .ARST_N, .BUS_ADDR, .BUS_WDATA, .BUS_WRITE,
        .BUS_READ, .BUS_RDATA, .CMP_RAW, .AMP0_OUT, .AMP1_OUT, .CMP_ON, .CMP_BIAS,
        .CMP_RESULT, .AMP0_ENABLE, .AMP0_SWITCH, .AMP0_TRIM, .AMP1_ENABLE,
        .AMP1_SWITCH, .AMP1_TRIM, .IRQ);

    // Free-running system clock of 100 ns.
    always #50 CLK_SYS = ~CLK_SYS;

    // One-cycle register write; the new value is visible after the edge.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK_SYS);
        BUS_WRITE <= 1'b1; BUS_ADDR <= a; BUS_WDATA <= d;
        @(posedge CLK_SYS);
        BUS_WRITE <= 1'b0;
        #1;
    endtask

    // One-cycle register read; data stands only in the following cycle.
    task automatic rd(input logic [3:0] a, input logic [7:0] x);
        @(posedge CLK_SYS);
        BUS_READ <= 1'b1; BUS_ADDR <= a;
        @(posedge CLK_SYS);
        BUS_READ <= 1'b0;
        #1 `CHK("rdata", x, BUS_RDATA)
    endtask

    // Waits a number of edges and settles past them.
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask

    // Drives the comparator pin by a non-blocking assignment at a rising edge.
    task automatic pin(input logic v);
        @(posedge CLK_SYS);
        CMP_RAW <= v;
    endtask

    // Offset calibration of each amplifier: mode, reference, trim steps, then normal mode.
    task automatic t_cal();
        for (int a = 0; a < 2; a++) begin
            wr(4'h1 + 4'(a), 8'hA0);
            `CHK("cal_ref0", 3'h6, a ? AMP1_SWITCH : AMP0_SWITCH)
            wr(4'h1 + 4'(a), 8'hB0);
            `CHK("cal_ref1", 3'h5, a ? AMP1_SWITCH : AMP0_SWITCH)
            for (int t = 1; t < 6; t++) begin
                wr(4'h1 + 4'(a), 8'hB0 | 8'(t));
            end
            @(posedge CLK_SYS);
            {AMP1_OUT, AMP0_OUT} <= 2'(a + 1);
            tick(3);
            rd(4'h1 + 4'(a), 8'hF5);
            `CHK("trim", 4'h5, a ? AMP1_TRIM : AMP0_TRIM)
            `CHK("amp_en", 1'b1, a ? AMP1_ENABLE : AMP0_ENABLE)
            wr(4'h1 + 4'(a), 8'h85);
            `CHK("cal_end", 3'h3, a ? AMP1_SWITCH : AMP0_SWITCH)
        end
        @(posedge CLK_SYS);
        AMP1_OUT <= 1'b0;
        tick(4);
        rd(4'h4, 8'h06);
    endtask

    // Reset values, unmapped reads and the four switch decodes of both amplifiers.
    task automatic t_regs();
        rd(4'h0, 8'h00);
        `CHK("sw", 3'h3, AMP0_SWITCH)
        rd(4'hF, 8'h00);
        for (int i = 0; i < 4; i++) begin
            e = !i[1] ? 3'h3 : (i[0] ? 3'h5 : 3'h6);
            wr(4'h1, {2'h0, i[1:0], 4'h0});
            wr(4'h2, {2'h0, i[1:0], 4'h0});
            `CHK("sw0", e, AMP0_SWITCH)
            `CHK("sw1", e, AMP1_SWITCH)
        end
    endtask

    // Polarity, read-only result bit, unused top bit and bias codes.
    task automatic t_cmp();
        wr(4'h0, 8'hE0);
        tick(4);
        `CHK("inv", 1'b1, CMP_RESULT)
        rd(4'h0, 8'h70);
        pin(1'b1);
        tick(4);
        rd(4'h0, 8'h60);
        for (int b = 0; b < 3; b++) begin
            wr(4'h0, {6'h10, b[1:0]});
            `CHK("bias", b[1:0], CMP_BIAS)
        end
        wr(4'h0, 8'h13);
        rd(4'h0, 8'h02);
        `CHK("on", 1'b0, CMP_ON)
    endtask

    // Glitch rejection at four and sixteen clocks and exact settling time for each filter length.
    task automatic t_dbc();
        for (int s = 1; s < 4; s++) begin
            len = (s == 1) ? 1 : (s == 2) ? 4 : 16;
            pin(1'b0);
            wr(4'h0, {4'h4, s[1:0], 2'h0});
            tick(20);
            if (len > 1) begin
                pin(1'b1);
                repeat (len - 2) @(posedge CLK_SYS);
                pin(1'b0);
                tick(20);
                `CHK("glitch", 1'b0, CMP_RESULT)
            end
            pin(1'b1);
            tick(len + 1);
            `CHK("early", 1'b0, CMP_RESULT)
            tick(1);
            `CHK("late", 1'b1, CMP_RESULT)
        end
        wr(4'h0, 8'h00);
        `CHK("off", 1'b0, CMP_RESULT)
    endtask

    // Rising-edge interrupt raised, read, cleared and masked.
    task automatic t_irq();
        pin(1'b0);
        wr(4'h3, 8'h01);
        wr(4'h0, 8'h40);
        tick(4);
        wr(4'h4, 8'h07);
        wr(4'h5, 8'h01);
        `CHK("quiet", 1'b0, IRQ)
        pin(1'b1);
        tick(6);
        `CHK("irq", 1'b1, IRQ)
        rd(4'h4, 8'h01);
        wr(4'h5, 8'h00);
        `CHK("mask", 1'b0, IRQ)
        wr(4'h4, 8'h01);
        rd(4'h4, 8'h00);
        wr(4'h3, 8'h02);
        pin(1'b0);
        tick(4);
        rd(4'h4, 8'h01);
        wr(4'h3, 8'h03);
        wr(4'h4, 8'h01);
        pin(1'b1);
        tick(4);
        rd(4'h4, 8'h00);
        wr(4'h3, 8'h00);
        wr(4'h0, 8'h00);
        rd(4'h4, 8'h01);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Main sequence after a reset of 20 clocks.
    initial begin
        repeat (20) @(posedge CLK_SYS);
        ARST_N <= 1'b1;
        t_regs();
        t_cal();
        t_cmp();
        t_dbc();
        t_irq();
        final_report();
    end

    // Watchdog well beyond the few hundred cycles the tests take.
    initial begin
        #(5000 * 100);
        n_errors++;
        final_report();
    end
endmodule
`default_nettype wire
